/* File: rtl/dpcp_core.sv */
// Purpose: dual polarization autocorrelation datapath
// Assumes: samples, gates and markers arrive on mclk; reference is a pin
// Notes: results leave one slot per cycle after each dwell
`include "dpcp_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dpcp_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] if_sample,
  input wire logic if_valid,
  input wire logic pulse_start,
  input wire logic tx_pol_v,
  input wire logic burst_gate,
  input wire logic noise_gate,
  input wire logic ref_clk_in,
  output logic samp_sync,
  output logic trig_out,
  output logic busy,
  output logic res_valid,
  output logic [3:0] res_bin,
  output logic [2:0] res_chan,
  output logic signed [31:0] res_t0,
  output logic signed [31:0] res_r0,
  output logic signed [31:0] res_r1_re,
  output logic signed [31:0] res_r1_im,
  output logic signed [31:0] res_r2_re,
  output logic signed [31:0] res_r2_im,
  output logic signed [31:0] res_xc_re,
  output logic signed [31:0] res_xc_im
);

  localparam int NB = `DPCP_NBINS;
  localparam int NS = `DPCP_NSLOT;

  // ==========================================================
  // Functions
  function automatic logic signed [7:0] dpcp_cos(input logic [2:0] p);
    case (p)
      3'h0: return 8'sh7f;
      3'h1: return 8'sh5a;
      3'h2: return 8'sh00;
      3'h3: return -8'sh5a;
      3'h4: return -8'sh7f;
      3'h5: return -8'sh5a;
      3'h6: return 8'sh00;
      default: return 8'sh5a;
    endcase
  endfunction

  // a*b + c*d, widened to accumulator width
  function automatic logic signed [39:0] dpcp_mac(
    input logic signed [15:0] a, input logic signed [15:0] b,
    input logic signed [15:0] c, input logic signed [15:0] d);
    logic signed [32:0] p;
    p = 33'(a * b) + 33'(c * d);
    return 40'(p);
  endfunction

  // a*b - c*d
  function automatic logic signed [39:0] dpcp_msc(
    input logic signed [15:0] a, input logic signed [15:0] b,
    input logic signed [15:0] c, input logic signed [15:0] d);
    logic signed [32:0] p;
    p = 33'(a * b) - 33'(c * d);
    return 40'(p);
  endfunction

  function automatic logic signed [31:0] dpcp_mean(
    input logic signed [39:0] sum, input logic [8:0] n);
    if (n == 9'h000) begin
      return 32'sh0;
    end
    return 32'(sum / $signed({1'b0, n}));
  endfunction

  // Lag-0 noise removal, floor at zero
  function automatic logic signed [31:0] dpcp_nsub(
    input logic signed [31:0] v, input logic [31:0] nz, input logic en);
    if (!en) begin
      return v;
    end
    if (v > $signed(nz)) begin
      return v - $signed(nz);
    end
    return 32'sh0;
  endfunction

  // Returns {enable, identity}; identity = {rx_v, tx_v}, {rx_v, rx_v} in simultaneous and {tx_v, tx_v} in alternating single
  function automatic logic [2:0] dpcp_slot(
    input dpcp_pkg::dpcp_case_t pc, input logic rx, input logic tx);
    case (pc)
      dpcp_pkg::DPCP_CASE_SIM: return {1'b1, rx, rx};
      dpcp_pkg::DPCP_CASE_ALT_SINGLE: return {~rx, tx, tx};
      default: return {1'b1, rx, tx}; // [RULE_09]
    endcase
  endfunction

  // ==========================================================
  // Control state
  dpcp_pkg::dpcp_state_t s_reg;
  dpcp_pkg::dpcp_state_t s_next;

  always_comb begin
    logic signed [27:0] pi;
    logic signed [27:0] pq;
    logic signed [27:0] si;
    logic signed [27:0] sq;
    logic [2:0] ph;
    logic edge_seen;
    pi = 28'sh0;
    pq = 28'sh0;
    si = 28'sh0;
    sq = 28'sh0;
    ph = 3'h0;
    edge_seen = 1'b0;
    s_next = s_reg;
    s_next.bin_valid = 1'b0;
    s_next.samp_sync = 1'b0;
    s_next.trig = 1'b0;

    // Register writes and reads
    if (reg_wr) begin
      case (reg_addr)
        `DPCP_ADDR_CTRL: begin
          s_next.pcase = dpcp_pkg::dpcp_case_t'(
            reg_wdata[`DPCP_CTRL_CASE_LSB +: 2]); // [RULE_05]
          s_next.nsub_en = reg_wdata[`DPCP_CTRL_NSUB_BIT];
          s_next.pol_filt = reg_wdata[`DPCP_CTRL_POLF_BIT];
          s_next.fsel = reg_wdata[`DPCP_CTRL_FSEL_LSB +: 4];
          s_next.klystron = reg_wdata[`DPCP_CTRL_KLY_BIT];
        end
        `DPCP_ADDR_DWELL: s_next.dwell_m = reg_wdata[7:0];
        `DPCP_ADDR_PHINC_H: s_next.phinc[0] = reg_wdata;
        `DPCP_ADDR_PHINC_V: s_next.phinc[1] = reg_wdata;
        `DPCP_ADDR_TRIG_DIV: s_next.trig_div = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `DPCP_ADDR_CTRL: s_next.rdata = {23'h0, s_reg.klystron,
          s_reg.fsel, s_reg.pol_filt, s_reg.nsub_en, s_reg.pcase};
        `DPCP_ADDR_DWELL: s_next.rdata = {24'h0, s_reg.dwell_m};
        `DPCP_ADDR_PHINC_H: s_next.rdata = s_reg.phinc[0];
        `DPCP_ADDR_PHINC_V: s_next.rdata = s_reg.phinc[1];
        `DPCP_ADDR_TRIG_DIV: s_next.rdata = {24'h0, s_reg.trig_div};
        `DPCP_ADDR_STATUS: s_next.rdata = {29'h0, s_reg.noise_ok,
          s_reg.st == dpcp_pkg::DPCP_ST_READ, s_reg.locked};
        `DPCP_ADDR_NOISE_H: s_next.rdata = s_reg.noise[0];
        `DPCP_ADDR_NOISE_V: s_next.rdata = s_reg.noise[1];
        `DPCP_ADDR_BURST_H: s_next.rdata = s_reg.burst[0];
        `DPCP_ADDR_BURST_V: s_next.rdata = s_reg.burst[1];
        default: s_next.rdata = 32'h0;
      endcase
    end

    // Reference lock, sample sync and triggers
    s_next.ref_s1 = ref_clk_in;
    s_next.ref_s2 = s_reg.ref_s1;
    s_next.ref_s3 = s_reg.ref_s2;
    edge_seen = s_reg.ref_s2 & ~s_reg.ref_s3;
    if (edge_seen) begin
      s_next.lock_cnt = 9'h000;
      s_next.locked = 1'b1;
      s_next.samp_sync = 1'b1; // [RULE_04]
      if (s_reg.locked) begin
        if (s_reg.trig_cnt + 8'h01 >= s_reg.trig_div) begin
          s_next.trig_cnt = 8'h00;
          s_next.trig = 1'b1; // [RULE_04]
        end else begin
          s_next.trig_cnt = s_reg.trig_cnt + 8'h01;
        end
      end
    end else if (s_reg.lock_cnt == 9'(`DPCP_LOCK_TIMEOUT_CYC)) begin
      s_next.locked = 1'b0;
      s_next.trig_cnt = 8'h00;
    end else begin
      s_next.lock_cnt = s_reg.lock_cnt + 9'h001;
    end

    // Pulse start
    if (pulse_start) begin
      s_next.dec_cnt = 3'h0;
      s_next.acc_i = '0;
      s_next.acc_q = '0;
      s_next.bin_ctr = 4'h0;
      s_next.tx_v = tx_pol_v;
      s_next.pulse_active = (s_reg.st == dpcp_pkg::DPCP_ST_ACC);
    end else if (if_valid) begin
      s_next.dec_cnt = (s_reg.dec_cnt == `DPCP_DEC) ? 3'h0 :
        s_reg.dec_cnt + 3'h1;
      // Mix each IF to baseband, integrate and dump
      for (int c = 0; c < 2; c++) begin
        ph = s_reg.phase[c][31:29];
        s_next.phase[c] = s_reg.phase[c] + s_reg.phinc[c];
        pi = 28'(if_sample * dpcp_cos(ph));
        pq = -28'(if_sample * dpcp_cos(ph - 3'h2));
        si = $signed(s_reg.acc_i[c]) + pi;
        sq = $signed(s_reg.acc_q[c]) + pq;
        if (s_reg.dec_cnt == `DPCP_DEC) begin
          s_next.acc_i[c] = '0;
          s_next.acc_q[c] = '0;
          s_next.bin_i[c] = 16'(si >>> `DPCP_DEC_SHIFT); // [RULE_01]
          s_next.bin_q[c] = 16'(sq >>> `DPCP_DEC_SHIFT); // [RULE_08]
          if (burst_gate) begin
            // Same path for burst and reference oscillator samples
            s_next.burst[c] = {s_next.bin_i[c],
              s_next.bin_q[c]}; // [RULE_02] [RULE_03]
          end
        end else begin
          s_next.acc_i[c] = si;
          s_next.acc_q[c] = sq;
        end
      end
      if (s_reg.dec_cnt == `DPCP_DEC && !burst_gate) begin
        if (noise_gate) begin
          for (int c = 0; c < 2; c++) begin
            s_next.noise_acc[c] = s_reg.noise_acc[c] + 40'(dpcp_mac(
              s_next.bin_i[c], s_next.bin_i[c],
              s_next.bin_q[c], s_next.bin_q[c]));
          end
          s_next.noise_n = s_reg.noise_n + 7'h01;
          if (s_next.noise_n == `DPCP_NOISE_N) begin
            for (int c = 0; c < 2; c++) begin
              s_next.noise[c] = 32'(s_next.noise_acc[c]
                >> `DPCP_NOISE_LOG); // [RULE_15]
            end
            s_next.noise_ok = 1'b1;
            s_next.noise_n = 7'h00;
            s_next.noise_acc = '0;
          end
        end else if (s_reg.pulse_active) begin
          s_next.bin_valid = 1'b1;
          s_next.bin_idx = s_reg.bin_ctr;
          s_next.bin_ctr = s_reg.bin_ctr + 4'h1;
          if (s_reg.bin_ctr == 4'(NB - 1)) begin
            s_next.pulse_active = 1'b0;
          end
        end
      end
    end
    if (!noise_gate) begin
      s_next.noise_acc = '0;
      s_next.noise_n = 7'h00;
    end

    // Dwell sequencing
    case (s_reg.st)
      dpcp_pkg::DPCP_ST_ACC: begin
        if (s_reg.bin_valid && s_reg.bin_idx == 4'(NB - 1)) begin
          s_next.fprev_ok = 1'b1;
          s_next.pulse_cnt = s_reg.pulse_cnt + 8'h01;
          if (s_reg.pulse_cnt + 8'h01 >= s_reg.dwell_m) begin
            s_next.st = dpcp_pkg::DPCP_ST_READ; // [RULE_20]
            s_next.rd_bin = 4'h0;
            s_next.rd_slot = 3'h0;
          end
        end
      end
      dpcp_pkg::DPCP_ST_READ: begin
        s_next.pulse_active = 1'b0;
        if (s_reg.rd_slot == 3'(NS - 1)) begin
          s_next.rd_slot = 3'h0;
          s_next.rd_bin = s_reg.rd_bin + 4'h1;
          if (s_reg.rd_bin == 4'(NB - 1)) begin
            s_next.st = dpcp_pkg::DPCP_ST_ACC;
            s_next.pulse_cnt = 8'h00;
          end
        end else begin
          s_next.rd_slot = s_reg.rd_slot + 3'h1;
        end
      end
      default: s_next.st = dpcp_pkg::DPCP_ST_ACC;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.dwell_m <= `DPCP_DWELL_RST;
      s_reg.trig_div <= `DPCP_TRIG_DIV_RST;
      s_reg.phinc[0] <= `DPCP_PHINC_H_RST;
      s_reg.phinc[1] <= `DPCP_PHINC_V_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign samp_sync = s_reg.samp_sync;
  assign trig_out = s_reg.trig;
  assign busy = (s_reg.st == dpcp_pkg::DPCP_ST_READ);

  // ==========================================================
  // Sample series selection
  logic signed [15:0] raw_i [2];
  logic signed [15:0] raw_q [2];
  logic signed [15:0] pol_i [2];
  logic signed [15:0] pol_q [2];
  logic signed [15:0] std_i [2];
  logic signed [15:0] std_q [2];
  logic signed [15:0] rprev_i [2][NB];
  logic signed [15:0] rprev_q [2][NB];
  logic filt_on;

  assign filt_on = (s_reg.fsel != 4'h0); // [RULE_17] [RULE_19]

  always_comb begin
    logic signed [16:0] di;
    logic signed [16:0] dq;
    di = 17'sh0;
    dq = 17'sh0;
    for (int c = 0; c < 2; c++) begin
      raw_i[c] = $signed(s_reg.bin_i[c]);
      raw_q[c] = $signed(s_reg.bin_q[c]);
      // Two-pulse canceller as the clutter filter
      di = 17'(raw_i[c]) - 17'(rprev_i[c][s_reg.bin_idx]);
      dq = 17'(raw_q[c]) - 17'(rprev_q[c][s_reg.bin_idx]);
      std_i[c] = (filt_on && s_reg.fprev_ok) ? 16'(di >>> 1) : raw_i[c];
      std_q[c] = (filt_on && s_reg.fprev_ok) ? 16'(dq >>> 1) : raw_q[c];
      pol_i[c] = s_reg.pol_filt ? std_i[c] : raw_i[c]; // [RULE_18]
      pol_q[c] = s_reg.pol_filt ? std_q[c] : raw_q[c];
    end
  end

  // ==========================================================
  // Slot routing: 0 hh, 1 hv, 2 vh, 3 vv, 4 standard moments
  logic [NS-1:0] slot_on;
  logic [NS-1:0] slot_ch;
  logic [2:0] map0;
  logic [2:0] map1;
  logic std_ch;

  assign map0 = dpcp_slot(s_reg.pcase, 1'b0, s_reg.tx_v);
  assign map1 = dpcp_slot(s_reg.pcase, 1'b1, s_reg.tx_v);
  assign std_ch = (s_reg.pcase == dpcp_pkg::DPCP_CASE_FIXED ||
    s_reg.pcase == dpcp_pkg::DPCP_CASE_ALT_DUAL) ? s_reg.tx_v : 1'b0;

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_slot
      if (g < 4) begin : g_pol
        assign slot_ch[g] = map1[2] && map1[1:0] == 2'(g);
        assign slot_on[g] = s_reg.bin_valid && ((map0[2] &&
          map0[1:0] == 2'(g)) || slot_ch[g]); // [RULE_12]
      end else begin : g_std
        assign slot_ch[g] = std_ch;
        assign slot_on[g] = s_reg.bin_valid; // [RULE_06]
      end
    end
  endgenerate

  // ==========================================================
  // Per-bin accumulation memories and readout
  logic signed [15:0] p1_i [NS][NB];
  logic signed [15:0] p1_q [NS][NB];
  logic signed [15:0] p2_i [NS][NB];
  logic signed [15:0] p2_q [NS][NB];
  logic signed [39:0] a_t0 [NS][NB];
  logic signed [39:0] a_r0 [NS][NB];
  logic signed [39:0] a_r1r [NS][NB];
  logic signed [39:0] a_r1i [NS][NB];
  logic signed [39:0] a_r2r [NS][NB];
  logic signed [39:0] a_r2i [NS][NB];
  logic signed [39:0] a_xr [2][NB];
  logic signed [39:0] a_xi [2][NB];
  logic [8:0] cnt [NS];
  logic [8:0] xcnt [2];
  logic last_bin;
  logic dual_rx;
  logic xt;
  logic [3:0] b;
  logic [2:0] k;
  logic nz_idx;

  assign b = s_reg.bin_idx;
  assign last_bin = s_reg.bin_valid && b == 4'(NB - 1);
  assign dual_rx = (s_reg.pcase != dpcp_pkg::DPCP_CASE_ALT_SINGLE);
  assign xt = (s_reg.pcase == dpcp_pkg::DPCP_CASE_SIM) ? 1'b0 : s_reg.tx_v;
  assign k = s_reg.rd_slot;
  assign nz_idx = (k == 3'(NS - 1)) ? std_ch : k[1];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        cnt[i] <= 9'h000;
      end
      xcnt[0] <= 9'h000;
      xcnt[1] <= 9'h000;
      res_valid <= 1'b0;
      res_bin <= 4'h0;
      res_chan <= 3'h0;
      res_t0 <= 32'sh0;
      res_r0 <= 32'sh0;
      res_r1_re <= 32'sh0;
      res_r1_im <= 32'sh0;
      res_r2_re <= 32'sh0;
      res_r2_im <= 32'sh0;
      res_xc_re <= 32'sh0;
      res_xc_im <= 32'sh0;
    end else begin
      res_valid <= 1'b0;
      if (s_reg.bin_valid) begin
        for (int c = 0; c < 2; c++) begin
          rprev_i[c][b] <= raw_i[c];
          rprev_q[c][b] <= raw_q[c];
        end
      end
      // Gains cancel and are never applied [RULE_13]
      for (int i = 0; i < NS; i++) begin
        if (slot_on[i]) begin
          automatic logic signed [15:0] si = (i == NS - 1) ?
            std_i[slot_ch[i]] : pol_i[slot_ch[i]];
          automatic logic signed [15:0] sq = (i == NS - 1) ?
            std_q[slot_ch[i]] : pol_q[slot_ch[i]];
          automatic logic signed [15:0] ri = raw_i[slot_ch[i]];
          automatic logic signed [15:0] rq = raw_q[slot_ch[i]];
          p1_i[i][b] <= si;
          p1_q[i][b] <= sq;
          p2_i[i][b] <= p1_i[i][b];
          p2_q[i][b] <= p1_q[i][b];
          a_t0[i][b] <= (cnt[i] == 9'h000 ? 40'sh0 : a_t0[i][b]) +
            dpcp_mac(ri, ri, rq, rq); // [RULE_11] [RULE_20]
          a_r0[i][b] <= (cnt[i] == 9'h000 ? 40'sh0 : a_r0[i][b]) +
            dpcp_mac(si, si, sq, sq); // [RULE_10]
          if (cnt[i] >= 9'h001) begin
            // Current times conjugate of previous [RULE_07]
            a_r1r[i][b] <= (cnt[i] == 9'h001 ? 40'sh0 : a_r1r[i][b]) +
              dpcp_mac(si, p1_i[i][b], sq, p1_q[i][b]);
            a_r1i[i][b] <= (cnt[i] == 9'h001 ? 40'sh0 : a_r1i[i][b]) +
              dpcp_msc(sq, p1_i[i][b], si, p1_q[i][b]);
          end
          if (cnt[i] >= 9'h002) begin
            a_r2r[i][b] <= (cnt[i] == 9'h002 ? 40'sh0 : a_r2r[i][b]) +
              dpcp_mac(si, p2_i[i][b], sq, p2_q[i][b]);
            a_r2i[i][b] <= (cnt[i] == 9'h002 ? 40'sh0 : a_r2i[i][b]) +
              dpcp_msc(sq, p2_i[i][b], si, p2_q[i][b]);
          end
          if (last_bin) begin
            cnt[i] <= cnt[i] + 9'h001;
          end
        end
      end
      // Cross channel: rx V times conjugate of rx H
      if (s_reg.bin_valid && dual_rx) begin
        a_xr[xt][b] <= (xcnt[xt] == 9'h000 ? 40'sh0 : a_xr[xt][b]) +
          dpcp_mac(pol_i[1], pol_i[0], pol_q[1], pol_q[0]);
        a_xi[xt][b] <= (xcnt[xt] == 9'h000 ? 40'sh0 : a_xi[xt][b]) +
          dpcp_msc(pol_q[1], pol_i[0], pol_i[1], pol_q[0]);
        if (last_bin) begin
          xcnt[xt] <= xcnt[xt] + 9'h001;
        end
      end
      if (s_reg.st == dpcp_pkg::DPCP_ST_READ) begin
        res_valid <= 1'b1;
        res_bin <= s_reg.rd_bin;
        res_chan <= k;
        res_t0 <= dpcp_nsub(dpcp_mean(a_t0[k][s_reg.rd_bin], cnt[k]),
          s_reg.noise[nz_idx], s_reg.nsub_en); // [RULE_16]
        res_r0 <= dpcp_nsub(dpcp_mean(a_r0[k][s_reg.rd_bin], cnt[k]),
          s_reg.noise[nz_idx], s_reg.nsub_en); // [RULE_14]
        res_r1_re <= dpcp_mean(a_r1r[k][s_reg.rd_bin],
          cnt[k] > 9'h001 ? cnt[k] - 9'h001 : 9'h000); // [RULE_10]
        res_r1_im <= dpcp_mean(a_r1i[k][s_reg.rd_bin],
          cnt[k] > 9'h001 ? cnt[k] - 9'h001 : 9'h000);
        res_r2_re <= dpcp_mean(a_r2r[k][s_reg.rd_bin],
          cnt[k] > 9'h002 ? cnt[k] - 9'h002 : 9'h000);
        res_r2_im <= dpcp_mean(a_r2i[k][s_reg.rd_bin],
          cnt[k] > 9'h002 ? cnt[k] - 9'h002 : 9'h000);
        res_xc_re <= dpcp_mean(a_xr[k[0]][s_reg.rd_bin], xcnt[k[0]]);
        res_xc_im <= dpcp_mean(a_xi[k[0]][s_reg.rd_bin], xcnt[k[0]]);
        if (k == 3'(NS - 1) && s_reg.rd_bin == 4'(NB - 1)) begin
          for (int i = 0; i < NS; i++) begin
            cnt[i] <= 9'h000; // [RULE_20]
          end
          xcnt[0] <= 9'h000;
          xcnt[1] <= 9'h000;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/dpcp_defines.svh */
// Function
// RULE_01 - Separate two IF channels from one digitized stream by filtering.
// RULE_02 - Burst samples at both IFs yield per-channel transmit I and Q.
// RULE_03 - Klystron reference samples go through the burst path unchanged.
// RULE_04 - Sampling sync and triggers locked to external 2-60 MHz reference.
// RULE_05 - Cases: fixed, simultaneous, alternating single or dual receive.
// RULE_06 - Standard moment autocorrelations are produced in every case.
// RULE_07 - Only pulse pair processing is implemented for all cases.
// RULE_08 - Each sample is complex: I real, Q imaginary, per pulse and bin.
// RULE_09 - Channel identity is receive then transmit polarization.
// RULE_10 - Lag-0 mean over M, lag-1 over M-1, lag-2 over M-2 pairs.
// RULE_11 - Total power lag-0 always from unfiltered samples.
// RULE_12 - Autocorrelation runs on up to four channel identities at once.
// RULE_13 - All channel gains taken as unity.
// RULE_14 - Noise subtraction touches lag-0 powers only.
// RULE_15 - Noise powers come from own noise sampling measurement.
// RULE_16 - Noise enable subtracts matching receive channel noise from powers.
// RULE_17 - Standard moments filtered whenever filter select is nonzero.
// RULE_18 - Polarization filtered setting chooses filtered or raw series.
// RULE_19 - All-pass filter zero leaves polarization series unfiltered.
// RULE_20 - Accumulators restart each dwell; results out after last pulse.
//
// Purpose: constants of the dual polarization correlation processor
// Assumes: 250 MHz mclk, 16-bit composite IF samples
// Notes: register offsets are byte addresses of 32-bit words
`ifndef DPCP_DEFINES_SVH
`define DPCP_DEFINES_SVH

`define DPCP_NBINS 16
`define DPCP_NSLOT 5
`define DPCP_DEC 3'h7
`define DPCP_DEC_SHIFT 11
`define DPCP_NOISE_LOG 6
`define DPCP_NOISE_N 7'h40

`define DPCP_CLK_MHZ 250
`define DPCP_REF_MIN_MHZ 2
`define DPCP_REF_MAX_PER_CYC (`DPCP_CLK_MHZ / `DPCP_REF_MIN_MHZ)
`define DPCP_LOCK_TIMEOUT_CYC (2 * `DPCP_REF_MAX_PER_CYC)

`define DPCP_ADDR_CTRL 8'h00
`define DPCP_ADDR_DWELL 8'h04
`define DPCP_ADDR_PHINC_H 8'h08
`define DPCP_ADDR_PHINC_V 8'h0c
`define DPCP_ADDR_TRIG_DIV 8'h10
`define DPCP_ADDR_STATUS 8'h14
`define DPCP_ADDR_NOISE_H 8'h18
`define DPCP_ADDR_NOISE_V 8'h1c
`define DPCP_ADDR_BURST_H 8'h20
`define DPCP_ADDR_BURST_V 8'h24

`define DPCP_CTRL_CASE_LSB 0
`define DPCP_CTRL_NSUB_BIT 2
`define DPCP_CTRL_POLF_BIT 3
`define DPCP_CTRL_FSEL_LSB 4
`define DPCP_CTRL_KLY_BIT 8

`define DPCP_DWELL_RST 8'h20
`define DPCP_PHINC_H_RST 32'h1999_999a
`define DPCP_PHINC_V_RST 32'h147a_e148
`define DPCP_TRIG_DIV_RST 8'h01

`endif

/* File: rtl/dpcp_pkg.sv */
// Purpose: types of the dual polarization correlation processor
// Assumes: dpcp_defines.svh constants
// Notes: control state of the core is one packed struct
`include "dpcp_defines.svh"

package dpcp_pkg;

  typedef enum logic [1:0] {
    DPCP_CASE_FIXED = 2'b00,
    DPCP_CASE_SIM = 2'b01,
    DPCP_CASE_ALT_SINGLE = 2'b10,
    DPCP_CASE_ALT_DUAL = 2'b11
  } dpcp_case_t;

  typedef enum logic {
    DPCP_ST_ACC = 1'b0,
    DPCP_ST_READ = 1'b1
  } dpcp_st_t;

  typedef struct packed {
    dpcp_st_t st;
    dpcp_case_t pcase;
    logic nsub_en;
    logic pol_filt;
    logic [3:0] fsel;
    logic klystron;
    logic [7:0] dwell_m;
    logic [7:0] trig_div;
    logic [1:0][31:0] phinc;
    logic [1:0][31:0] phase;
    logic [2:0] dec_cnt;
    logic [1:0][27:0] acc_i;
    logic [1:0][27:0] acc_q;
    logic [1:0][15:0] bin_i;
    logic [1:0][15:0] bin_q;
    logic bin_valid;
    logic [3:0] bin_idx;
    logic [3:0] bin_ctr;
    logic pulse_active;
    logic tx_v;
    logic [7:0] pulse_cnt;
    logic fprev_ok;
    logic [1:0][31:0] burst;
    logic [3:0] rd_bin;
    logic [2:0] rd_slot;
    logic [1:0][39:0] noise_acc;
    logic [6:0] noise_n;
    logic [1:0][31:0] noise;
    logic noise_ok;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic samp_sync;
    logic [7:0] trig_cnt;
    logic [8:0] lock_cnt;
    logic locked;
    logic trig;
    logic [31:0] rdata;
  } dpcp_state_t;

endpackage

/* File: dv/dpcp_core_props.sv */
// Purpose: port checks for dpcp_core
// Assumes: one clock, synchronous reset
// Notes: bound at the foot
`timescale 1ns/100ps
`default_nettype none
// ====
// Checks
module dpcp_core_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ref_clk_in,
  input wire logic samp_sync,
  input wire logic trig_out,
  input wire logic busy,
  input wire logic res_valid,
  input wire logic [3:0] res_bin,
  input wire logic [2:0] res_chan,
  input wire logic signed [31:0] res_t0
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence first_s;
    res_valid && res_bin == 4'h0 && res_chan == 3'h0;
  endsequence
  sequence run_s;
    res_valid [*7];
  endsequence
  ref_sync_a: assert property (
    $rose(ref_clk_in) |-> ##[2:5] samp_sync) else $error("no sync");
  sync_pulse_a: assert property (
    samp_sync |=> !samp_sync) else $error("sync long");
  trig_pulse_a: assert property (
    trig_out |=> !trig_out) else $error("trig long");
  readout_a: assert property (
    $rose(busy) |=> first_s ##1 run_s) else $error("readout");
  chan_step_a: assert property (
    res_valid && res_chan < 3'h4 |=> res_valid &&
    res_chan == $past(res_chan) + 3'h1 && $stable(res_bin))
    else $error("chan step");
  bin_step_a: assert property (
    res_valid && res_chan == 3'h4 && res_bin != 4'hf |=> res_valid &&
    res_chan == 3'h0 && res_bin == $past(res_bin) + 4'h1)
    else $error("bin step");
  chan_range_a: assert property (
    res_valid |-> res_chan <= 3'h4) else $error("chan range");
  power_sign_a: assert property (
    res_valid |-> !res_t0[31]) else $error("neg power");
endmodule
bind dpcp_core dpcp_core_props i_props (.mclk, .rst_n, .ref_clk_in,
  .samp_sync, .trig_out, .busy, .res_valid, .res_bin, .res_chan, .res_t0);
`default_nettype wire

/* File: dv/dpcp_if_model.sv */
// Purpose: IF digitizer stream model
// Assumes: one pulse of 16 bins per go
// Notes: reference runs free at 6.25 MHz
`timescale 1ns/100ps
`default_nettype none
// ====
// Stream source
module dpcp_if_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic pol,
  input wire logic nm,
  input wire logic [15:0] amp,
  output logic [15:0] if_sample,
  output logic if_valid,
  output logic pulse_start,
  output logic tx_pol_v,
  output logic noise_gate,
  output logic ref_clk_in,
  output logic done
);
  int n = 129;
  int r = 0;
  assign done = n == 129;
  initial {if_sample, if_valid, pulse_start, tx_pol_v} = '0;
  initial {noise_gate, ref_clk_in} = '0;
  always @(posedge mclk) begin
    r <= r == 19 ? 0 : r + 1;
    if (r == 19) ref_clk_in <= !ref_clk_in;
    pulse_start <= go;
    if_valid <= !go && n < 128;
    // Idle line toggles so a stale value never looks valid
    if_sample <= !go && n < 128 ? amp : ~if_sample;
    if (go) begin
      n <= 0;
      tx_pol_v <= pol;
      noise_gate <= nm;
    end else if (n < 129) begin
      n <= n + 1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/dpcp_core_tb.sv */
// Purpose: self-checking bench for dpcp_core
// Assumes: zero phase steps so pulses repeat exactly
// Notes: model predicts word order and zero terms
`timescale 1ns/100ps
`default_nettype none
// ====
// Bench
module dpcp_core_tb;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0, pol = 0, nm = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, t0, r0, r1i, r2i;
  logic [15:0] amp = 0, if_sample;
  logic if_valid, pulse_start, tx_pol_v, noise_gate, ref_clk_in, done;
  logic samp_sync, trig_out, busy, res_valid, bg = 0;
  logic [3:0] res_bin;
  logic [2:0] res_chan;
  int error_cnt = 0, check_count = 0, seed = 53004, q[$];
  always #2 mclk = ~mclk;
  dpcp_if_model i_src (.mclk, .go, .pol, .nm, .amp, .if_sample, .if_valid,
    .pulse_start, .tx_pol_v, .noise_gate, .ref_clk_in, .done);
  dpcp_core i_dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .if_sample, .if_valid, .pulse_start, .tx_pol_v,
    .burst_gate(bg), .noise_gate, .ref_clk_in, .samp_sync, .trig_out,
    .busy, .res_valid, .res_bin, .res_chan, .res_t0(t0), .res_r0(r0),
    .res_r1_re(), .res_r1_im(r1i), .res_r2_re(), .res_r2_im(r2i),
    .res_xc_re(), .res_xc_im());
  task chk(input string s, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, v);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
    @(posedge mclk);
  endtask
  task pulse(input logic p, input logic n, input logic [15:0] a);
    int k;
    {go, pol, nm, amp} <= {1'b1, p, n, a};
    @(posedge mclk);
    go <= 1'b0;
    k = 0;
    do @(posedge mclk); while (!done && ++k < 400);
    if (done !== 1'b1) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task collect(input logic [15:0] a, input logic [3:0] f, input logic pf,
    input logic ns);
    int k, w, e;
    for (k = 0; k < 80; k++) q.push_back(k);
    // Mixer gain 127/256 at zero phase; noise pulses gave 127 squared
    e = int'(a) * 127 / 256;
    e = e * e - (ns ? 127 * 127 : 0);
    for (k = 0; k < 900 && q.size() > 0; k++) begin
      @(posedge mclk);
      #1;
      if (res_valid === 1'b1) begin
        w = q.pop_front();
        chk("bin_chan", w / 5 * 8 + w % 5, {res_bin, res_chan});
        chk("r1_im", 0, r1i);
        chk("r2_im", 0, r2i);
        if (a == 0) chk("t0", 0, t0);
        if (w % 5 == 4) chk("t0_std", e, t0);
        if (f == 0 || !pf && w % 5 < 4) chk("r0", t0, r0);
        if (f != 0 && w % 5 == 4) chk("filt", 1, r0 < t0);
      end
    end
    chk("words", 0, q.size());
    if (q.size() > 0) tally_and_finish;
    @(posedge mclk);
  endtask
  initial begin
    int d, j, m;
    logic [15:0] a;
    logic [3:0] f;
    logic pf;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h04, 32'h20);
    rd(8'h10, 32'h1);
    rd(8'h08, 32'h1999999a);
    rd(8'h40, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h0);
    repeat (4) pulse(1'b0, 1'b1, 16'h100);
    rd(8'h14, 32'h5);
    rd(8'h18, 32'h3f01);
    bg <= 1'b1;
    pulse(1'b0, 1'b0, 16'h1000);
    bg <= 1'b0;
    rd(8'h20, 32'h07f00000);
    rd(8'h24, 32'h07f00000);
    for (d = 0; d < 6; d++) begin
      a = d == 0 ? 16'h0 : 16'h1000 | 16'($random(seed) & 32'hfff);
      f = d > 3 ? 4'h1 : 4'h0;
      pf = d == 2 || d == 5;
      m = 3 + ($random(seed) & 3);
      wr(8'h04, m);
      wr(8'h00, {f, pf, d[0], d[1:0]});
      for (j = 0; j < m; j++) pulse(j[0] & d[1], 1'b0, a);
      collect(a, f, pf, d[0]);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
